// ---- design/ofd_operand_decoder.sv ----
// operand field decoder core: decodes one operand request into an address or value
//
// Overview of operation
// - bit operand is a 3-bit field selecting bit zero through seven.
// - direct address operand is a full 16-bit program address.
// - extended register operand is a 12-bit register-file address.
// - immediate operand is one byte used as the value itself.
// - register and indirect register operands are 8-bit addresses; indirect reads pointer.
// - working pair operands select only even working registers zero to fourteen.
// - 8-bit register pair addresses, direct or indirect, must be even.
// - polarity operand is a single bit, zero or one.
// - relative operand is signed 8-bit, added to next instruction address.
// - indexed operand adds signed 8-bit index to register or pair value.
// - trap vector operand is 8 bits selecting one of 256 vectors.
// - two-operand arithmetic combines both and writes result to destination.
// - object code normally holds source byte before destination byte, opcode dependent.
// - 8-bit register field with high nibble E selects a working register.
module ofd_operand_decoder (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // request from fetch
  input  wire logic        i_valid,
  input  wire logic [4:0]  i_mode,
  input  wire logic [7:0]  i_byte0,
  input  wire logic [7:0]  i_byte1,
  input  wire logic        i_src_first,
  // cpu context
  input  wire logic [7:0]  i_working_register_base_pointer,
  input  wire logic [15:0] i_next_pc,
  input  wire logic [15:0] i_index_base,
  // arithmetic data
  input  wire logic [7:0]  i_src_data,
  input  wire logic [7:0]  i_dst_data,
  input  wire logic        i_use_carry,
  input  wire logic        i_carry_in,
  // pointer read port
  input  wire logic        i_rd_ack,
  input  wire logic [15:0] i_rd_data,
  output logic             o_rd_req,
  output logic [11:0]      o_rd_addr,
  // decode result
  output logic             o_busy,
  output logic             o_done,
  output logic [15:0]      o_addr,
  output logic             o_is_reg,
  output logic [7:0]       o_value,
  output logic [7:0]       o_bit_mask,
  output logic             o_polarity,
  output logic             o_bad,
  // destination writeback
  output logic             o_wb_en,
  output logic [11:0]      o_wb_addr,
  output logic [7:0]       o_wb_data,
  output logic             o_carry
);

  // ---------------------------------------------------------------
  // state and captured request
  // ---------------------------------------------------------------
  ofd_pkg::ofd_state_t state_q;
  ofd_pkg::ofd_state_t state_d;
  ofd_pkg::ofd_mode_t  mode_q;
  logic [7:0]          byte0_q;
  logic [7:0]          byte1_q;
  logic                src_first_q;

  ofd_pkg::ofd_mode_t  cur_mode;
  logic [7:0]          cur_b0;
  logic [7:0]          cur_b1;
  logic                cur_src_first;
  logic [7:0]          src_byte;
  logic [7:0]          dst_byte;
  logic                idle;
  logic                accept;
  logic                finish;

  ofd_calc_if calc ();

  assign idle          = (state_q == ofd_pkg::OFD_ST_IDLE);
  assign accept        = idle && i_valid;
  assign cur_mode      = idle ? ofd_pkg::ofd_mode_t'(i_mode) : mode_q;
  assign cur_b0        = idle ? i_byte0 : byte0_q;
  assign cur_b1        = idle ? i_byte1 : byte1_q;
  assign cur_src_first = idle ? i_src_first : src_first_q;
  assign src_byte      = cur_src_first ? cur_b0 : cur_b1;
  assign dst_byte      = cur_src_first ? cur_b1 : cur_b0;

  // ---------------------------------------------------------------
  // mappers and adder
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_map
      ofd_reg_map #(.IDX(g)) u_map (
        .bus (calc.mapper)
      );
    end
  endgenerate

  ofd_offset_add u_add (
    .bus (calc.adder)
  );

  logic [7:0] map_in0;
  logic [7:0] map_in1;

  always_comb begin
    map_in0 = cur_b0;
    map_in1 = cur_b1;
    case (cur_mode)
      ofd_pkg::OFD_WREG,
      ofd_pkg::OFD_IWREG: begin
        map_in0 = {ofd_pkg::ESC_NIBBLE, cur_b0[3:0]};
      end
      ofd_pkg::OFD_WPAIR,
      ofd_pkg::OFD_IWPAIR: begin
        map_in0 = {ofd_pkg::ESC_NIBBLE, cur_b0[3:1], 1'b0};
      end
      ofd_pkg::OFD_RPAIR,
      ofd_pkg::OFD_IRPAIR: begin
        map_in0 = {cur_b0[7:1], 1'b0};
      end
      ofd_pkg::OFD_ARITH: begin
        map_in0 = src_byte;
        map_in1 = dst_byte;
      end
      default: begin
        map_in0 = cur_b0;
      end
    endcase
  end

  assign calc.base_ptr    = i_working_register_base_pointer;
  assign calc.map_raw[0]  = map_in0;
  assign calc.map_raw[1]  = map_in1;
  assign calc.add_base    = (cur_mode == ofd_pkg::OFD_REL) ? i_next_pc : i_index_base;
  assign calc.add_off     = cur_b0;

  // ---------------------------------------------------------------
  // result decode
  // ---------------------------------------------------------------
  logic [15:0] d_addr;
  logic        d_is_reg;
  logic [7:0]  d_value;
  logic [7:0]  d_mask;
  logic        d_pol;
  logic        d_bad;
  logic        d_wb_en;
  logic [8:0]  d_sum;
  logic [7:0]  page;

  assign page = {4'h0, i_working_register_base_pointer[ofd_pkg::RP_PAGE_HI:ofd_pkg::RP_PAGE_LO]};

  always_comb begin
    d_addr   = ofd_pkg::RST_ADDR;
    d_is_reg = 1'b0;
    d_value  = ofd_pkg::RST_BYTE;
    d_mask   = ofd_pkg::RST_BYTE;
    d_pol    = 1'b0;
    d_bad    = 1'b0;
    d_wb_en  = 1'b0;
    d_sum    = {1'b0, i_dst_data} + {1'b0, i_src_data} + {8'h00, i_use_carry & i_carry_in};
    case (cur_mode)
      ofd_pkg::OFD_BIT: begin
        d_value = {5'h00, cur_b0[ofd_pkg::BIT_W-1:0]};
        d_mask  = ofd_pkg::MASK_ONE << cur_b0[ofd_pkg::BIT_W-1:0];
      end
      ofd_pkg::OFD_POL: begin
        d_pol   = cur_b0[ofd_pkg::POL_POS];
        d_value = {7'h00, cur_b0[ofd_pkg::POL_POS]};
      end
      ofd_pkg::OFD_WREG,
      ofd_pkg::OFD_REG,
      ofd_pkg::OFD_WPAIR,
      ofd_pkg::OFD_RPAIR: begin
        d_addr   = {4'h0, calc.map_addr[0]};
        d_is_reg = 1'b1;
        d_bad    = ((cur_mode == ofd_pkg::OFD_WPAIR) || (cur_mode == ofd_pkg::OFD_RPAIR))
                   && cur_b0[ofd_pkg::PAIR_LSB];
      end
      ofd_pkg::OFD_IWREG,
      ofd_pkg::OFD_IREG: begin
        d_addr   = {page, i_rd_data[7:0]};
        d_is_reg = 1'b1;
      end
      ofd_pkg::OFD_IWPAIR,
      ofd_pkg::OFD_IRPAIR: begin
        d_addr = i_rd_data;
        d_bad  = cur_b0[ofd_pkg::PAIR_LSB];
      end
      ofd_pkg::OFD_EXTREG: begin
        d_addr   = {4'h0, cur_b0[3:0], cur_b1};
        d_is_reg = 1'b1;
      end
      ofd_pkg::OFD_IMM: begin
        d_value = cur_b0;
      end
      ofd_pkg::OFD_DIRADDR: begin
        d_addr = {cur_b0, cur_b1};
      end
      ofd_pkg::OFD_REL,
      ofd_pkg::OFD_INDEX: begin
        d_addr = calc.add_sum;
      end
      ofd_pkg::OFD_VECTOR: begin
        d_value = cur_b0;
        d_addr  = {8'h00, cur_b0};
      end
      ofd_pkg::OFD_ARITH: begin
        d_addr   = {4'h0, calc.map_addr[1]};
        d_is_reg = 1'b1;
        d_value  = d_sum[7:0];
        d_wb_en  = 1'b1;
      end
      default: begin
        d_bad = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  assign finish = (accept && !ofd_pkg::ofd_is_indirect(cur_mode)) ||
                  (!idle && i_rd_ack);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ofd_pkg::OFD_ST_IDLE: begin
        if (accept && ofd_pkg::ofd_is_indirect(cur_mode)) begin
          state_d = ofd_pkg::OFD_ST_WAIT;
        end
      end
      ofd_pkg::OFD_ST_WAIT: begin
        if (i_rd_ack) begin
          state_d = ofd_pkg::OFD_ST_IDLE;
        end
      end
      default: begin
        state_d = ofd_pkg::OFD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ofd_pkg::OFD_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q      <= ofd_pkg::OFD_BIT;
      byte0_q     <= ofd_pkg::RST_BYTE;
      byte1_q     <= ofd_pkg::RST_BYTE;
      src_first_q <= 1'b0;
    end else if (accept) begin
      mode_q      <= ofd_pkg::ofd_mode_t'(i_mode);
      byte0_q     <= i_byte0;
      byte1_q     <= i_byte1;
      src_first_q <= i_src_first;
    end
  end

  // pointer read request held until acknowledged
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_req  <= 1'b0;
      o_rd_addr <= ofd_pkg::RST_EXT;
    end else if (accept && ofd_pkg::ofd_is_indirect(cur_mode)) begin
      o_rd_req  <= 1'b1;
      o_rd_addr <= calc.map_addr[0];
    end else if (i_rd_ack) begin
      o_rd_req  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done     <= 1'b0;
      o_addr     <= ofd_pkg::RST_ADDR;
      o_is_reg   <= 1'b0;
      o_value    <= ofd_pkg::RST_BYTE;
      o_bit_mask <= ofd_pkg::RST_BYTE;
      o_polarity <= 1'b0;
      o_bad      <= 1'b0;
    end else begin
      o_done <= finish;
      if (finish) begin
        o_addr     <= d_addr;
        o_is_reg   <= d_is_reg;
        o_value    <= d_value;
        o_bit_mask <= d_mask;
        o_polarity <= d_pol;
        o_bad      <= d_bad;
      end
    end
  end

  // destination writeback, one-cycle strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_en   <= 1'b0;
      o_wb_addr <= ofd_pkg::RST_EXT;
      o_wb_data <= ofd_pkg::RST_BYTE;
      o_carry   <= 1'b0;
    end else begin
      o_wb_en <= finish && d_wb_en;
      if (finish && d_wb_en) begin
        o_wb_addr <= calc.map_addr[1];
        o_wb_data <= d_sum[7:0];
        o_carry   <= d_sum[8];
      end
    end
  end

  assign o_busy = state_q[1];

endmodule : ofd_operand_decoder

// ---- design/ofd_pkg.sv ----
// constants, operand kinds and helper functions for the operand field decoder
package ofd_pkg;

  // ---------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------
  localparam int unsigned BIT_W    = 3;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned EXT_W    = 12;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned WREG_W   = 4;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam logic [3:0]  ESC_NIBBLE   = 4'he;
  localparam int unsigned ESC_HI       = 7;
  localparam int unsigned ESC_LO       = 4;
  localparam int unsigned POL_POS      = 0;
  localparam int unsigned PAIR_LSB     = 0;
  localparam int unsigned RP_PAGE_HI   = 3;
  localparam int unsigned RP_PAGE_LO   = 0;
  localparam int unsigned RP_GROUP_HI  = 7;
  localparam int unsigned RP_GROUP_LO  = 4;

  // ---------------------------------------------------------------
  // reset values and the single-bit mask
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_ADDR   = 16'h0000;
  localparam logic [11:0] RST_EXT    = 12'h000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  MASK_ONE   = 8'h01;

  // ---------------------------------------------------------------
  // operand kinds
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OFD_BIT     = 5'h00,
    OFD_POL     = 5'h01,
    OFD_WREG    = 5'h02,
    OFD_IWREG   = 5'h03,
    OFD_WPAIR   = 5'h04,
    OFD_IWPAIR  = 5'h05,
    OFD_REG     = 5'h06,
    OFD_IREG    = 5'h07,
    OFD_RPAIR   = 5'h08,
    OFD_IRPAIR  = 5'h09,
    OFD_EXTREG  = 5'h0a,
    OFD_IMM     = 5'h0b,
    OFD_DIRADDR = 5'h0c,
    OFD_REL     = 5'h0d,
    OFD_INDEX   = 5'h0e,
    OFD_VECTOR  = 5'h0f,
    OFD_ARITH   = 5'h10
  } ofd_mode_t;

  typedef enum logic [1:0] {
    OFD_ST_IDLE = 2'b01,
    OFD_ST_WAIT = 2'b10
  } ofd_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // working register index onto a register-file address
  function automatic logic [11:0] ofd_wreg_addr(input logic [7:0] rp, input logic [3:0] n);
    ofd_wreg_addr = {rp[RP_PAGE_HI:RP_PAGE_LO], rp[RP_GROUP_HI:RP_GROUP_LO], n};
  endfunction : ofd_wreg_addr

  function automatic logic ofd_is_indirect(input ofd_mode_t m);
    ofd_is_indirect = (m == OFD_IWREG) || (m == OFD_IREG) ||
                      (m == OFD_IWPAIR) || (m == OFD_IRPAIR);
  endfunction : ofd_is_indirect

endpackage : ofd_pkg

// ---- design/ofd_calc_if.sv ----
// carrier between the decoder core, its address mappers and its offset adder
interface ofd_calc_if;
  logic [7:0]  base_ptr;
  logic [7:0]  map_raw  [2];
  logic [11:0] map_addr [2];
  logic [15:0] add_base;
  logic [7:0]  add_off;
  logic [15:0] add_sum;

  modport mapper (input base_ptr, input map_raw, output map_addr);
  modport adder  (input add_base, input add_off, output add_sum);
  modport core   (output base_ptr, output map_raw, output add_base, output add_off,
                  input map_addr, input add_sum);
endinterface : ofd_calc_if

// ---- design/ofd_reg_map.sv ----
// 8-bit register field onto a 12-bit register-file address, with escape
module ofd_reg_map #(
  parameter int unsigned IDX = 0
) (
  ofd_calc_if.mapper bus
);

  logic [7:0] raw;
  logic       esc;

  assign raw = bus.map_raw[IDX];
  assign esc = (raw[ofd_pkg::ESC_HI:ofd_pkg::ESC_LO] == ofd_pkg::ESC_NIBBLE);

  // escaped form picks a working register, plain form stays in the current page
  assign bus.map_addr[IDX] = esc ? ofd_pkg::ofd_wreg_addr(bus.base_ptr, raw[3:0])
                                 : {bus.base_ptr[ofd_pkg::RP_PAGE_HI:ofd_pkg::RP_PAGE_LO],
                                    raw};

endmodule : ofd_reg_map

// ---- design/ofd_offset_add.sv ----
// signed 8-bit displacement added to a 16-bit base
module ofd_offset_add (
  ofd_calc_if.adder bus
);

  logic [15:0] off_ext;

  assign off_ext     = {{8{bus.add_off[7]}}, bus.add_off};
  assign bus.add_sum = bus.add_base + off_ext;

endmodule : ofd_offset_add

// ---- tb/ofd_chk_assertions.sv ----
// port-level checks on the operand field decoder
module ofd_chk (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // request side
  input wire logic        i_valid,
  input wire logic [4:0]  i_mode,
  input wire logic [7:0]  i_byte0,
  input wire logic [7:0]  i_byte1,
  input wire logic [7:0]  i_working_register_base_pointer,
  input wire logic [15:0] i_next_pc,
  input wire logic [15:0] i_index_base,
  input wire logic        i_rd_ack,
  // result side
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_rd_req,
  input wire logic [15:0] o_addr,
  input wire logic [7:0]  o_value,
  input wire logic [7:0]  o_bit_mask,
  input wire logic        o_polarity,
  input wire logic        o_bad,
  input wire logic        o_wb_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic        acc;
  logic [4:0]  m_q;
  logic [7:0]  b0_q;
  logic [7:0]  b1_q;
  logic [7:0]  rp_q;
  logic [15:0] pc_q;
  logic [15:0] ib_q;
  assign acc = i_valid && !o_busy;
  always_ff @(posedge i_clk) begin
    m_q  <= i_mode;
    b0_q <= i_byte0;
    b1_q <= i_byte1;
    rp_q <= i_working_register_base_pointer;
    pc_q <= i_next_pc;
    ib_q <= i_index_base;
  end
  a_bit_mask:
    assert property (acc && i_mode == 5'h00 |=> o_done && o_value == {5'h0, b0_q[2:0]}
      && o_bit_mask == 8'h01 << b0_q[2:0]) else $error("bit select wrong");
  a_direct_addr:
    assert property (acc && i_mode == 5'h0c |=> o_addr == {b0_q, b1_q}) else $error("direct addr");
  a_ext_reg:
    assert property (acc && i_mode == 5'h0a |=> o_addr == {4'h0, b0_q[3:0], b1_q})
      else $error("ext reg addr");
  a_imm_value:
    assert property (acc && i_mode == 5'h0b |=> o_value == b0_q) else $error("imm value");
  a_pol_bit:
    assert property (acc && i_mode == 5'h01 |=> o_polarity == b0_q[0]) else $error("polarity");
  a_rel_target:
    assert property (acc && i_mode == 5'h0d |=> o_addr == pc_q + {{8{b0_q[7]}}, b0_q})
      else $error("rel target");
  a_index_sum:
    assert property (acc && i_mode == 5'h0e |=> o_addr == ib_q + {{8{b0_q[7]}}, b0_q})
      else $error("index sum");
  a_vector_addr:
    assert property (acc && i_mode == 5'h0f |=> o_addr == {8'h00, b0_q}) else $error("vector");
  a_pair_even:
    assert property (acc && (i_mode == 5'h04 || i_mode == 5'h08) |=> !o_addr[0]
      && o_bad == b0_q[0]) else $error("pair not even");
  a_wreg_map:
    assert property (acc && i_mode == 5'h02 |=> o_addr == {4'h0, rp_q[3:0], rp_q[7:4],
      b0_q[3:0]}) else $error("wreg map");
  a_ptr_start:
    assert property (acc && i_mode == 5'h07 |=> o_busy && o_rd_req && !o_done)
      else $error("ptr read start");
  a_ptr_done:
    assert property (i_rd_ack && o_busy |=> o_done && !o_busy && !o_rd_req)
      else $error("ptr read end");
  a_wb_only:
    assert property (acc |=> o_wb_en == (m_q == 5'h10)
      && o_done != (m_q inside {5'h03, 5'h05, 5'h07, 5'h09})) else $error("writeback");
endmodule : ofd_chk

bind ofd_operand_decoder ofd_chk u_chk (
  .i_clk, .i_rst, .i_valid, .i_mode, .i_byte0, .i_byte1,
  .i_working_register_base_pointer, .i_next_pc, .i_index_base, .i_rd_ack,
  .o_busy, .o_done, .o_rd_req, .o_addr, .o_value, .o_bit_mask, .o_polarity, .o_bad, .o_wb_en
);

// ---- tb/ofd_ptr_model.sv ----
// pointer register responder, answering after a chosen stall
module ofd_ptr_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // read port
  input  wire logic        i_rd_req,
  input  wire logic [11:0] i_rd_addr,
  input  wire logic [1:0]  i_wait,
  output logic             o_rd_ack,
  output logic [15:0]      o_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q     <= 2'h0;
      o_rd_ack  <= 1'b0;
      o_rd_data <= 16'h0;
    end else if (i_rd_req && !o_rd_ack && cnt_q == i_wait) begin
      o_rd_ack  <= 1'b1;
      o_rd_data <= {i_rd_addr[7:0], ~i_rd_addr[7:0]};
    end else begin
      o_rd_ack  <= 1'b0;
      // data toggles outside the answer cycle
      o_rd_data <= ~o_rd_data;
      cnt_q     <= (i_rd_req && !o_rd_ack) ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule : ofd_ptr_model

// ---- tb/tb_top.sv ----
// self-checking bench for the operand field decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0]  mode;
    logic [31:0] val;
    logic        bad;
    logic        isr;
  } ofd_note_t;
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, sf = 1'b0, uc = 1'b0, ci = 1'b0;
  logic [4:0] mode = 5'h0;
  logic [7:0] b0 = 8'h0, b1 = 8'h0, rp = 8'h0, sd = 8'h0, dd = 8'h0;
  logic [15:0] pc = 16'h0, ib = 16'h0;
  logic [1:0] wt = 2'h0;
  logic rd_ack, rd_req, busy, done, pol, bad, wb_en, carry, is_reg;
  logic [15:0] rd_data, addr;
  logic [11:0] rd_addr, wb_addr;
  logic [7:0] value, mask, wb_data;
  logic [31:0] seed = 32'h9b400164;
  ofd_note_t notes[$];
  int num_errors = 0, total_checks = 0, cycles = 0;

  always #5 clk = ~clk;

  ofd_operand_decoder dut (.i_clk(clk), .i_rst(rst), .i_valid(valid), .i_mode(mode),
    .i_byte0(b0), .i_byte1(b1), .i_src_first(sf), .i_working_register_base_pointer(rp),
    .i_next_pc(pc), .i_index_base(ib), .i_src_data(sd), .i_dst_data(dd), .i_use_carry(uc),
    .i_carry_in(ci), .i_rd_ack(rd_ack), .i_rd_data(rd_data), .o_rd_req(rd_req),
    .o_rd_addr(rd_addr), .o_busy(busy), .o_done(done), .o_addr(addr), .o_is_reg(is_reg),
    .o_value(value), .o_bit_mask(mask), .o_polarity(pol), .o_bad(bad), .o_wb_en(wb_en),
    .o_wb_addr(wb_addr), .o_wb_data(wb_data), .o_carry(carry));
  ofd_ptr_model u_mem (.i_clk(clk), .i_rst(rst), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
    .i_wait(wt), .o_rd_ack(rd_ack), .o_rd_data(rd_data));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    rnd = seed;
  endfunction : rnd

  function automatic logic [11:0] map_f(input logic [7:0] x);
    map_f = (x[7:4] == 4'he) ? {rp[3:0], rp[7:4], x[3:0]} : {rp[3:0], x};
  endfunction : map_f

  // expected result from the request held on the inputs
  function automatic logic [31:0] expect_f(input logic [4:0] m);
    logic [8:0]  sum;
    logic [11:0] a;
    sum = {1'b0, dd} + {1'b0, sd} + {8'h0, uc & ci};
    case (m)
      5'h02, 5'h03: a = map_f({4'he, b0[3:0]});
      5'h04, 5'h05: a = map_f({4'he, b0[3:1], 1'b0});
      5'h08, 5'h09: a = map_f({b0[7:1], 1'b0});
      default:      a = map_f(b0);
    endcase
    case (m)
      5'h00:                      expect_f = {16'h0, 8'h01 << b0[2:0], 5'h0, b0[2:0]};
      5'h01:                      expect_f = {31'h0, b0[0]};
      5'h02, 5'h04, 5'h06, 5'h08: expect_f = {20'h0, a};
      5'h03, 5'h07:               expect_f = {20'h0, rp[3:0], ~a[7:0]};
      5'h05, 5'h09:               expect_f = {16'h0, a[7:0], ~a[7:0]};
      5'h0a:                      expect_f = {20'h0, b0[3:0], b1};
      5'h0b, 5'h0f:               expect_f = {24'h0, b0};
      5'h0c:                      expect_f = {16'h0, b0, b1};
      5'h0d:                      expect_f = {16'h0, pc + {{8{b0[7]}}, b0}};
      5'h0e:                      expect_f = {16'h0, ib + {{8{b0[7]}}, b0}};
      5'h10:    expect_f = {10'h0, 1'b1, sum[8], map_f(sf ? b1 : b0), sum[7:0]};
      default:  expect_f = 32'h0;
    endcase
  endfunction : expect_f

  function automatic logic [31:0] seen_f(input logic [4:0] m);
    case (m)
      5'h00:   seen_f = {16'h0, mask, value};
      5'h01:   seen_f = {31'h0, pol};
      5'h0b:   seen_f = {24'h0, value};
      5'h10:   seen_f = {10'h0, wb_en, carry, wb_addr, wb_data};
      default: seen_f = (m > 5'h10) ? 32'h0 : {16'h0, addr};
    endcase
  endfunction : seen_f

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // request held until taken; note pushed at the taking edge
  task automatic send(input logic [4:0] m, input logic [7:0] x0);
    logic [31:0] r;
    valid <= 1'b1;
    mode  <= m;
    b0    <= x0;
    r = rnd();
    {b1, rp, sd, dd} <= r;
    r = rnd();
    {pc, ib} <= r;
    r = rnd();
    {sf, uc, ci, wt} <= r[4:0];
    do @(posedge clk); while (busy === 1'b1);
    notes.push_back('{m, expect_f(m), (m > 5'h10) || ((m == 5'h04 || m == 5'h05
      || m == 5'h08 || m == 5'h09) && b0[0]),
      m inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h10}});
    // pointer page is taken live at the answer, so context holds until done
    if (m inside {5'h03, 5'h05, 5'h07, 5'h09}) begin
      valid <= 1'b0;
      do @(posedge clk); while (done !== 1'b1);
    end
  endtask : send

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      test_done();
    end
  end

  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else begin
        ofd_note_t n;
        n = notes.pop_front();
        check(seen_f(n.mode), n.val);
        check({31'h0, bad}, {31'h0, n.bad});
        check({31'h0, is_reg}, {31'h0, n.isr});
      end
    end
  end

  initial begin
    logic [31:0] x;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // every mode at sign, parity and escape boundaries, then random
    for (int i = 0; i < 300; i++) begin
      x = rnd();
      if (i < 54) send(5'(i % 18), i < 18 ? 8'h80 : i < 36 ? 8'h7f : 8'he9);
      else send(5'(x % 18), x[15:8]);
      if (i == 53) $display("boundary sweep done");
    end
    valid <= 1'b0;
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(posedge clk);
    check(32'(notes.size()), 32'h0);
    $display("random sweep done");
    test_done();
  end
endmodule : tb_top
